// File: hw/pdsp_consts.svh
`ifndef PDSP_CONSTS_SVH
`define PDSP_CONSTS_SVH
// status codes driven on the processor status lines
`define PDSP_ST_CONTINUE 4'h0
`define PDSP_ST_BEGIN 4'h1
`define PDSP_ST_USER 4'h3
`define PDSP_ST_PULSE 4'h4
`define PDSP_ST_BRANCH 4'h5
`define PDSP_ST_RTE 4'h7
`define PDSP_ST_XFER_BASE 4'h8
`define PDSP_ST_EXCEPT 4'hC
`define PDSP_ST_EMU 4'hD
`define PDSP_ST_STOP 4'hE
`define PDSP_ST_HALT 4'hF
// test select bit meaning background debug
`define PDSP_SEL_DEBUG 1'b1
`endif

// File: hw/pdsp_pad.sv
`timescale 1ns/1ns
// output pad enable: scan control beats force-float, force-float is async
module pdsp_pad #(
	parameter int W = 4
) (
	input wire logic scan_active,
	input wire logic scan_oe,
	input wire logic force_high_impedance_n,
	input wire logic func_oe,
	output logic [W-1:0] oe
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_oe
			// combinational so the float needs no clock edge
			assign oe[i] = scan_active ? scan_oe :
				(force_high_impedance_n & func_oe);
		end
	endgenerate
endmodule

// File: hw/pdsp_pkg.sv
package pdsp_pkg;
	// event classes reported by the core, one per cycle
	typedef enum logic [3:0] {
		PDSP_EV_NONE,
		PDSP_EV_BEGIN,
		PDSP_EV_USER,
		PDSP_EV_PULSE,
		PDSP_EV_BRANCH,
		PDSP_EV_RTE,
		PDSP_EV_XFER,
		PDSP_EV_EXCEPT,
		PDSP_EV_EMU,
		PDSP_EV_STOP,
		PDSP_EV_HALT
	} pdsp_event_t;
	typedef enum logic {PDSP_IDLE, PDSP_SHIFT} pdsp_state_t;
endpackage

// File: hw/pdsp_top.sv
`timescale 1ns/1ns
`include "pdsp_consts.svh"
// How it works
// - status lines change on core clock edges
// - status clock is held high out of reset and never toggles
// - 0000 continue, 0001 begin, 0011 user
// - 0100 pulse, 0101 branch, 0111 return
// - 1000-1011 announce 1 to 4 byte transfers
// - 1100 except, 1101 emulator, 1110 stop, 1111 halt
// - codes 1100-1111 may hold many cycles
// - drive nibble bus with data and breakpoints
// - core clock times nibble and status lines
// - force-float input floats outputs asynchronously
// - scan control wins over force-float
// - scan pins shared, select bit 0 chooses
module pdsp_top (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire pdsp_pkg::pdsp_event_t EVENT_KIND,
	input wire logic [1:0] XFER_BYTES_M1,
	input wire logic [31:0] XFER_DATA,
	input wire logic [3:0] BREAK_STATUS,
	input wire logic BREAK_VALID,
	input wire logic [2:0] TEST_SELECT,
	input wire logic FORCE_HIGH_IMPEDANCE_N,
	input wire logic SCAN_OE,
	input wire logic XFER_READY_IN,
	output logic XFER_BUSY,
	output logic STATUS_CLOCK_OUT,
	output logic [3:0] PROCESSOR_STATUS_LINES,
	output logic [3:0] DEBUG_DATA_NIBBLE,
	output logic [3:0] STATUS_OE,
	output logic [3:0] NIBBLE_OE,
	output logic SCAN_MODE
);
	// transfer shifter state
	pdsp_pkg::pdsp_state_t state_r;
	logic [31:0] shift_r;
	logic [2:0] left_r;
	logic shifting;

	// status and mode decoding
	logic [3:0] status_nxt;
	logic [3:0] xfer_code;
	logic debug_sel;
	logic accept_xfer;
	logic scan_active;
	logic func_oe_r;

	// select bit 0 picks debug or scan; bits 2,1 assumed low
	assign debug_sel = (TEST_SELECT[0] == `PDSP_SEL_DEBUG);
	assign scan_active = ~debug_sel;
	assign shifting = (state_r == pdsp_pkg::PDSP_SHIFT);
	assign accept_xfer = (EVENT_KIND == pdsp_pkg::PDSP_EV_XFER) &&
		!shifting && debug_sel;

	// announce code: base plus byte count minus one
	assign xfer_code = `PDSP_ST_XFER_BASE | {2'b00, XFER_BYTES_M1};

	// status encoder, held codes simply repeat each cycle
	always_comb begin
		status_nxt = `PDSP_ST_CONTINUE;
		unique case (EVENT_KIND)
			pdsp_pkg::PDSP_EV_NONE: begin
				status_nxt = `PDSP_ST_CONTINUE;
			end
			pdsp_pkg::PDSP_EV_BEGIN: begin
				status_nxt = `PDSP_ST_BEGIN;
			end
			pdsp_pkg::PDSP_EV_USER: begin
				status_nxt = `PDSP_ST_USER;
			end
			pdsp_pkg::PDSP_EV_PULSE: begin
				status_nxt = `PDSP_ST_PULSE;
			end
			pdsp_pkg::PDSP_EV_BRANCH: begin
				status_nxt = `PDSP_ST_BRANCH;
			end
			pdsp_pkg::PDSP_EV_RTE: begin
				status_nxt = `PDSP_ST_RTE;
			end
			pdsp_pkg::PDSP_EV_XFER: begin
				// busy shifter: the transfer is not announced
				if (accept_xfer) begin
					status_nxt = xfer_code;
				end
			end
			pdsp_pkg::PDSP_EV_EXCEPT: begin
				status_nxt = `PDSP_ST_EXCEPT;
			end
			pdsp_pkg::PDSP_EV_EMU: begin
				status_nxt = `PDSP_ST_EMU;
			end
			pdsp_pkg::PDSP_EV_STOP: begin
				status_nxt = `PDSP_ST_STOP;
			end
			pdsp_pkg::PDSP_EV_HALT: begin
				status_nxt = `PDSP_ST_HALT;
			end
			default: begin
				status_nxt = `PDSP_ST_CONTINUE; // illegal codes
			end
		endcase
	end

	// status lines registered on the core clock
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PROCESSOR_STATUS_LINES <= `PDSP_ST_CONTINUE;
		end else begin
			PROCESSOR_STATUS_LINES <= status_nxt;
		end
	end

	// status clock: low in reset, then held high; it does not toggle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			STATUS_CLOCK_OUT <= 1'b0;
		end else begin
			STATUS_CLOCK_OUT <= 1'b1;
		end
	end

	// transfer sequencer: idle until accepted, shift until last nibble
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_r <= pdsp_pkg::PDSP_IDLE;
		end else begin
			unique case (state_r)
				pdsp_pkg::PDSP_IDLE: begin
					if (accept_xfer) begin
						state_r <= pdsp_pkg::PDSP_SHIFT;
					end
				end
				pdsp_pkg::PDSP_SHIFT: begin
					if (left_r == 3'h0) begin
						state_r <= pdsp_pkg::PDSP_IDLE;
					end
				end
			endcase
		end
	end

	// transfer word, next nibble always at the bottom
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			shift_r <= 32'h0000_0000;
		end else if (accept_xfer) begin
			shift_r <= XFER_DATA;
		end else if (shifting) begin
			shift_r <= {4'h0, shift_r[31:4]};
		end
	end

	// nibbles left after the current one, 2N-1 at start
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			left_r <= 3'h0;
		end else if (accept_xfer) begin
			left_r <= {XFER_BYTES_M1, 1'b1};
		end else if (shifting && left_r != 3'h0) begin
			left_r <= left_r - 3'h1;
		end
	end

	// nibble bus: transfer data, else breakpoint status
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			DEBUG_DATA_NIBBLE <= 4'h0;
		end else if (state_r == pdsp_pkg::PDSP_SHIFT) begin
			DEBUG_DATA_NIBBLE <= shift_r[3:0];
		end else if (BREAK_VALID) begin
			DEBUG_DATA_NIBBLE <= BREAK_STATUS;
		end else begin
			DEBUG_DATA_NIBBLE <= 4'h0;
		end
	end

	// busy flag back to the core
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			XFER_BUSY <= 1'b0;
		end else begin
			XFER_BUSY <= accept_xfer ||
				(state_r == pdsp_pkg::PDSP_SHIFT && left_r != 3'h0);
		end
	end

	// functional pad enable follows the debug selection
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			func_oe_r <= 1'b0;
		end else begin
			func_oe_r <= debug_sel;
		end
	end

	// mode flag seen by the board
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SCAN_MODE <= 1'b0;
		end else begin
			SCAN_MODE <= scan_active;
		end
	end

	// pad enables; the force-float path stays combinational
	pdsp_pad #(.W(4)) u_status_pad (
		.scan_active(scan_active),
		.scan_oe(SCAN_OE),
		.force_high_impedance_n(FORCE_HIGH_IMPEDANCE_N),
		.func_oe(func_oe_r),
		.oe(STATUS_OE)
	);
	pdsp_pad #(.W(4)) u_nibble_pad (
		.scan_active(scan_active),
		.scan_oe(SCAN_OE),
		.force_high_impedance_n(FORCE_HIGH_IMPEDANCE_N),
		.func_oe(func_oe_r),
		.oe(NIBBLE_OE)
	);

	logic unused_ok;
	assign unused_ok = XFER_READY_IN ^ TEST_SELECT[2] ^ TEST_SELECT[1];
endmodule

// File: verification/pdsp_probe.sv
`timescale 1ns/1ns
module pdsp_probe (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] st,
	input wire logic [3:0] nib,
	output logic [31:0] word_r,
	output logic [3:0] left_r
);
	// emulator side: collect announced nibbles on the core clock
	always_ff @(posedge clk) begin
		if (rst) begin
			left_r <= 4'h0;
			word_r <= 32'h0000_0000;
		end else if (left_r != 4'h0) begin
			word_r <= {nib, word_r[31:4]};
			left_r <= left_r - 4'h1;
		end else if (st[3:2] == 2'b10) begin
			left_r <= {1'b0, st[1:0], 1'b1} + 4'h1;
			word_r <= 32'h0000_0000;
		end
	end
endmodule

// File: verification/pdsp_properties.sv
`timescale 1ns/1ns
module pdsp_properties (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire pdsp_pkg::pdsp_event_t EVENT_KIND,
	input wire logic [1:0] XFER_BYTES_M1,
	input wire logic [31:0] XFER_DATA,
	input wire logic [2:0] TEST_SELECT,
	input wire logic FORCE_HIGH_IMPEDANCE_N,
	input wire logic SCAN_OE,
	input wire logic XFER_BUSY,
	input wire logic [3:0] PROCESSOR_STATUS_LINES,
	input wire logic [3:0] DEBUG_DATA_NIBBLE,
	input wire logic [3:0] STATUS_OE,
	input wire logic SCAN_MODE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// short aliases and accepted transfer
	pdsp_pkg::pdsp_event_t ev;
	logic [3:0] st;
	logic go;
	assign ev = EVENT_KIND;
	assign st = PROCESSOR_STATUS_LINES;
	assign go = ev == pdsp_pkg::PDSP_EV_XFER && !XFER_BUSY && TEST_SELECT[0];
	property p_rsv; st != 4'h2 && st != 4'h6; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code");
	property p_user; ev == pdsp_pkg::PDSP_EV_USER |=> st == 4'h3; endproperty
	a_user: assert property (p_user) else $error("user code");
	property p_rte; ev == pdsp_pkg::PDSP_EV_RTE |=> st == 4'h7; endproperty
	a_rte: assert property (p_rte) else $error("return code");
	property p_xfer; go |=> st == {2'b10, $past(XFER_BYTES_M1)}; endproperty
	a_xfer: assert property (p_xfer) else $error("xfer code");
	property p_hold;
		(ev == pdsp_pkg::PDSP_EV_STOP)[*3] |=> st == 4'hE && $past(st) == 4'hE;
	endproperty
	a_hold: assert property (p_hold) else $error("stop hold");
	property p_nib;
		go |-> ##2 DEBUG_DATA_NIBBLE == $past(XFER_DATA[3:0], 2);
	endproperty
	a_nib: assert property (p_nib) else $error("first nibble");
	property p_flt;
		TEST_SELECT[0] && !SCAN_MODE && !FORCE_HIGH_IMPEDANCE_N
			|-> STATUS_OE == 4'h0;
	endproperty
	a_flt: assert property (p_flt) else $error("not floated");
	property p_scan;
		!TEST_SELECT[0] && SCAN_MODE |-> STATUS_OE == {4{SCAN_OE}};
	endproperty
	a_scan: assert property (p_scan) else $error("scan lost");
endmodule
bind pdsp_top pdsp_properties pdsp_properties_inst (.*);

// File: verification/pdsp_top_tb_top.sv
`timescale 1ns/1ns
module pdsp_top_tb_top;
	logic clk = 0, rst = 1, hz_n = 1, soe = 0, bv = 0, busy, sclk, smode;
	logic [1:0] m1 = 2'h0;
	logic [2:0] tsel = 3'h1;
	logic [31:0] dat = 32'h8765_4321, word;
	logic [3:0] st, nib, soe_o, noe, left, brk = 4'h0;
	logic [3:0] tab [11] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8,
		4'hC, 4'hD, 4'hE, 4'hF};
	pdsp_pkg::pdsp_event_t ev = pdsp_pkg::PDSP_EV_NONE;
	int mismatches = 0, tests_run = 0;
	always #4 clk = ~clk;
	// block under test and emulator model
	pdsp_top pdsp_top_inst (.REF_CLK(clk), .RST(rst), .EVENT_KIND(ev),
		.XFER_BYTES_M1(m1), .XFER_DATA(dat), .BREAK_STATUS(brk),
		.BREAK_VALID(bv), .TEST_SELECT(tsel), .XFER_READY_IN(1'b0),
		.FORCE_HIGH_IMPEDANCE_N(hz_n), .SCAN_OE(soe), .XFER_BUSY(busy),
		.STATUS_CLOCK_OUT(sclk), .PROCESSOR_STATUS_LINES(st),
		.DEBUG_DATA_NIBBLE(nib), .STATUS_OE(soe_o), .NIBBLE_OE(noe),
		.SCAN_MODE(smode));
	pdsp_probe pdsp_probe_inst (.clk(clk), .rst(rst), .st(st), .nib(nib),
		.word_r(word), .left_r(left));
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task tally_and_finish;
		$display("mismatches %0d tests %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task t_codes;
		for (int i = 0; i < 11; i++) begin
			if (i == 6)
				continue;
			ev = pdsp_pkg::pdsp_event_t'(i);
			tick(1);
			chk(st, tab[i]);
		end
	endtask
	task t_hold;
		ev = pdsp_pkg::PDSP_EV_STOP;
		repeat (4) begin
			tick(1);
			chk(st, 4'hE);
		end
		ev = pdsp_pkg::PDSP_EV_NONE;
		tick(1);
	endtask
	task t_xfer;
		for (int n = 0; n < 4; n++) begin
			m1 = n[1:0];
			ev = pdsp_pkg::PDSP_EV_XFER;
			tick(1);
			chk(st, {2'b10, m1});
			chk(busy, 1'b1);
			tick(1);
			chk(st, 4'h0);
			ev = pdsp_pkg::PDSP_EV_NONE;
			tick(2 * n + 2);
			chk(word, dat << (24 - 8 * n));
			chk(busy, 1'b0);
		end
	endtask
	task t_reset;
		m1 = 2'h3;
		ev = pdsp_pkg::PDSP_EV_XFER;
		tick(2);
		rst = 1;
		ev = pdsp_pkg::PDSP_EV_NONE;
		tick(2);
		chk({busy, st, nib}, 9'h000);
		rst = 0;
		tick(1);
		chk({sclk, st}, 5'h10);
		m1 = 2'h0;
		ev = pdsp_pkg::PDSP_EV_XFER;
		tick(1);
		chk(st, 4'h8);
		ev = pdsp_pkg::PDSP_EV_NONE;
		tick(3);
		chk(word, dat << 24);
	endtask
	task t_break;
		brk = 4'h9;
		bv = 1;
		tick(1);
		chk(nib, 4'h9);
		bv = 0;
		tick(1);
		chk(nib, 4'h0);
	endtask
	task t_pins;
		hz_n = 0;
		#1;
		chk(soe_o | noe, 4'h0);
		tick(1);
		tsel = 3'h0;
		soe = 1;
		tick(2);
		chk({smode, soe_o, noe}, 9'h1FF);
		hz_n = 1;
		tsel = 3'h1;
		tick(2);
	endtask
	// main sequence and watchdog
	initial begin
		tick(20);
		chk({sclk, busy, smode, st, nib, soe_o}, 15'h0000);
		rst = 0;
		tick(1);
		chk({sclk, st}, 5'h10);
		t_codes;
		t_hold;
		t_xfer;
		t_reset;
		t_break;
		t_pins;
		tally_and_finish;
	end
	initial begin
		#20000;
		mismatches++;
		tally_and_finish;
	end
endmodule
